// *** hdl/crwag_top.sv ***
// cpu working register file, pointer pairs, wide access temp and change protection
//
// Behaviour
// RQ1: thirty-two 8-bit registers, single-cycle access
// RQ2: 8/8, 8+8/8or16, 16/16 port combinations
// RQ3: own address space, unreachable by loads/stores
// RQ4: 0x1a, 0x1c, 0x1e pair little-endian pointers
// RQ5: all pointers for data; third for table/indirect
// RQ6: displacement, post-increment, pre-decrement modes
// RQ7: low write to temp, high write commits
// RQ8: low read latches high; high read returns temp
// RQ9: other side accesses low byte first
// RQ10: temporary byte directly readable and writable
// RQ11: key 0xd8 opens four-instruction i/o window
// RQ12: key 0x9d opens four-instruction programming window
// RQ13: software sets change-enable bit with data
// RQ14: i/o window closes on writes, nvm, sleep
// RQ15: programming window closes on nvm, sleep
// RQ16: interrupts held pending while window open
// RQ17: key bit0/bit1 show open windows
// RQ18: key bits 7:2 read zero
// RQ19: other key values open nothing
// RQ20: stack pointer split low/high, unused bits zero
module crwag_top
  import crwag_pkg::*;
#(
  parameter logic [15:0] SP_RESET = 16'h3fff,
  parameter logic [15:0] SP_MASK = 16'h3fff
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register file
  input wire crwag_pkg::crwag_rf_req_t i_rf,
  output logic [7:0] o_rd_a,
  output logic [7:0] o_rd_b,
  output logic [15:0] o_rd_wide,
  // pointer unit
  input wire crwag_pkg::crwag_ptr_req_t i_ptr,
  output logic [15:0] o_ptr_addr,
  output logic [15:0] o_third_ptr,
  // i/o register bus
  input wire crwag_pkg::crwag_io_req_t i_io,
  output logic [7:0] o_io_rdata,
  // protection, stack pointer and flags
  input wire crwag_pkg::crwag_evt_t i_evt,
  input wire logic i_prot_wr,
  input wire logic i_nvm_cmd_wr,
  output logic o_prot_wr_ok,
  output logic o_nvm_cmd_ok,
  output logic o_irq_hold,
  output logic [15:0] o_stack_ptr,
  output logic [7:0] o_flags
);
  import crwag_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] gpr_r [REG_COUNT];
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] ptr_nxt;
  logic ptr_upd;
  logic [4:0] wr_hi_addr;

  // one 5-bit space of its own; the i/o bus never decodes into it
  assign wr_hi_addr = 5'(i_rf.wr_addr + 5'h1);  // RQ3
  assign ptr_lo = crwag_ptr_base(i_ptr.sel);
  assign ptr_val = {gpr_r[5'(ptr_lo + 5'h1)], gpr_r[ptr_lo]};  // RQ4
  // pointer modes; pre-decrement shows the lowered address
  assign ptr_nxt = (i_ptr.mode == CRWAG_PM_POSTINC) ? 16'(ptr_val + 16'h1) :
                   16'(ptr_val - 16'h1);  // RQ6
  assign ptr_upd = i_ptr.valid && (i_ptr.mode != CRWAG_PM_DISP);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) gpr_r[i] <= 8'h00;
    end else begin
      if (i_rf.we) begin
        gpr_r[i_rf.wr_addr] <= i_rf.wr_data[7:0];  // RQ1
        if (i_rf.we_wide) gpr_r[wr_hi_addr] <= i_rf.wr_data[15:8];  // RQ2
      end
      if (ptr_upd) begin
        gpr_r[ptr_lo] <= ptr_nxt[7:0];  // RQ6
        gpr_r[5'(ptr_lo + 5'h1)] <= ptr_nxt[15:8];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_a <= 8'h00;
      o_rd_b <= 8'h00;
      o_rd_wide <= 16'h0000;
      o_ptr_addr <= 16'h0000;
      o_third_ptr <= 16'h0000;
    end else begin
      o_rd_a <= gpr_r[i_rf.rd_a];  // RQ2
      o_rd_b <= gpr_r[i_rf.rd_b];
      o_rd_wide <= i_rf.wide_rd ? {gpr_r[5'(i_rf.rd_a + 5'h1)], gpr_r[i_rf.rd_a]} : 16'h0000;
      o_ptr_addr <= (i_ptr.mode == CRWAG_PM_DISP) ? 16'(ptr_val + {10'h000, i_ptr.disp}) :
                    (i_ptr.mode == CRWAG_PM_PREDEC) ? ptr_nxt : ptr_val;  // RQ5
      // table reads and indirect jumps see only the third pair
      o_third_ptr <= {gpr_r[PTR_C_LO + 5'h1], gpr_r[PTR_C_LO]};  // RQ5
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // i/o decode, temporary byte and stack pointer
  logic wr_key, wr_sp_lo, wr_sp_hi, rd_sp_lo, rd_sp_hi, wr_flags, wr_temp;
  logic [7:0] temp_r, temp_nxt, flags_r, key_rd, rdata_nxt;
  logic [15:0] sp_val;
  logic [7:0] sp_lo_rd;
  logic io_open, sp_open;

  assign wr_key = i_io.wr && (i_io.addr == OFS_PROT_KEY);
  assign wr_sp_lo = i_io.wr && (i_io.addr == OFS_STACK_LO);
  assign wr_sp_hi = i_io.wr && (i_io.addr == OFS_STACK_HI);
  assign rd_sp_lo = i_io.rd && (i_io.addr == OFS_STACK_LO);
  assign rd_sp_hi = i_io.rd && (i_io.addr == OFS_STACK_HI);
  assign wr_flags = i_io.wr && (i_io.addr == OFS_FLAGS);
  assign wr_temp = i_io.wr && (i_io.addr == OFS_TEMP);

  // low write parks data, low read parks the high half
  assign temp_nxt = (wr_sp_lo || wr_temp) ? i_io.wdata :  // RQ7 RQ10
                    rd_sp_lo ? sp_val[15:8] : temp_r;  // RQ8

  crwag_wide_reg #(
    .RST_VAL(SP_RESET),
    .IMPL_MASK(SP_MASK)
  ) u_sp (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_wr_lo(wr_sp_lo),
    .i_wr_hi(wr_sp_hi),
    .i_rd_lo(rd_sp_lo),
    .i_wdata(i_io.wdata),
    .i_temp(temp_r),
    .o_value(sp_val),
    .o_lo_rd(sp_lo_rd)
  );

  assign key_rd = {6'h00, sp_open, io_open};  // RQ17 RQ18

  always_comb begin
    case (i_io.addr)
      OFS_PROT_KEY: rdata_nxt = key_rd;
      OFS_STACK_LO: rdata_nxt = sp_lo_rd;  // RQ20
      OFS_STACK_HI: rdata_nxt = temp_r;  // RQ8
      OFS_FLAGS: rdata_nxt = flags_r;
      OFS_TEMP: rdata_nxt = temp_r;  // RQ10
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      temp_r <= RST_TEMP;
      flags_r <= RST_FLAGS;
      o_io_rdata <= 8'h00;
      o_stack_ptr <= 16'h0000;
      o_flags <= RST_FLAGS;
    end else begin
      temp_r <= temp_nxt;
      if (wr_flags) flags_r <= i_io.wdata;
      o_io_rdata <= i_io.rd ? rdata_nxt : 8'h00;
      o_stack_ptr <= sp_val;
      o_flags <= wr_flags ? i_io.wdata : flags_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // change protection windows
  logic key_io, key_sp, close_io, close_sp;

  assign key_io = wr_key && (i_io.wdata == KEY_IO_UNLOCK);  // RQ11 RQ19
  assign key_sp = wr_key && (i_io.wdata == KEY_SELF_PROG);  // RQ12 RQ19
  // the key write itself is not a closing write
  assign close_io = (i_evt.data_wr && !wr_key) || i_evt.nvm_ldst || i_evt.sleep_exec;  // RQ14
  assign close_sp = i_evt.nvm_ldst || i_evt.sleep_exec;  // RQ15

  crwag_guard u_io_win (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_key_wr(key_io),
    .i_key(i_io.wdata),
    .i_close(close_io),
    .i_instr_done(i_evt.instr_done),
    .o_open(io_open),
    .o_opening()
  );

  crwag_guard u_sp_win (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_key_wr(key_sp),
    .i_key(i_io.wdata),
    .i_close(close_sp),
    .i_instr_done(i_evt.instr_done),
    .o_open(sp_open),
    .o_opening()
  );

  // the protected write is allowed in the cycle it arrives, before the window closes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prot_wr_ok <= 1'b0;
      o_nvm_cmd_ok <= 1'b0;
      o_irq_hold <= 1'b0;
    end else begin
      o_prot_wr_ok <= i_prot_wr && io_open;  // RQ11
      o_nvm_cmd_ok <= i_nvm_cmd_wr && sp_open;  // RQ12
      o_irq_hold <= (io_open && !close_io) || (sp_open && !close_sp) || key_io || key_sp;  // RQ16
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_bad_key: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_key && !key_io && !key_sp && !io_open && !sp_open) |=> !io_open && !sp_open)
    else $error("unknown key opened a window");  // RQ19
  a_key_status: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_io.rd && i_io.addr == OFS_PROT_KEY) |=> o_io_rdata[7:2] == 6'h00 &&
      o_io_rdata[0] == $past(io_open) && o_io_rdata[1] == $past(sp_open))
    else $error("key register status bits wrong");  // RQ17
  a_sleep_close: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_evt.sleep_exec && !key_sp) |=> !sp_open)
    else $error("programming window survived sleep");  // RQ15
  a_temp_rd: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    rd_sp_lo && !wr_temp && !wr_sp_lo |=> temp_r == $past(sp_val[15:8]))
    else $error("low read did not latch high byte");  // RQ8
  a_nvm_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_nvm_cmd_wr && !sp_open) |=> !o_nvm_cmd_ok)
    else $error("nvm command passed with closed window");  // RQ12
  a_irq_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    key_io |=> o_irq_hold)
    else $error("interrupts not held on window open");  // RQ16
  a_gpr_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_rf.we && !ptr_upd) |=> gpr_r[$past(i_rf.wr_addr)] == $past(i_rf.wr_data[7:0]))
    else $error("register write lost");  // RQ1

  // a valid key write raises both the window and the interrupt hold one cycle later
  sequence s_key_io_wr;
    key_io && !close_io;
  endsequence
  sequence s_io_window_up;
    io_open && o_irq_hold;
  endsequence
  sequence s_sp_window_up;
    sp_open && o_irq_hold;
  endsequence
  a_io_open: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_key_io_wr |=> s_io_window_up)
    else $error("i/o key did not open the window");  // RQ11
  a_sp_open: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    key_sp |=> s_sp_window_up)
    else $error("programming key did not open the window");  // RQ12
  a_prot_block: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_prot_wr && !io_open) |=> !o_prot_wr_ok)
    else $error("protected write passed with closed window");  // RQ11
  a_prot_pass: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_prot_wr && io_open) |=> o_prot_wr_ok)
    else $error("protected write refused in open window");  // RQ11
  a_io_sleep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_evt.sleep_exec && !key_io) |=> !io_open)
    else $error("i/o window survived sleep");  // RQ14
  a_nvm_close: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_evt.nvm_ldst && !key_sp) |=> !sp_open)
    else $error("programming window survived nvm access");  // RQ15
  a_hold_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!io_open && !sp_open && !key_io && !key_sp) |=> !o_irq_hold)
    else $error("interrupts held with no window");  // RQ16
  // unused stack bits must never leak out, whatever is written
  a_sp_mask: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_stack_ptr & ~SP_MASK) == 16'h0000)
    else $error("unimplemented stack bits set");  // RQ20
  a_third_ptr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> o_third_ptr == $past({gpr_r[PTR_C_LO + 5'h1], gpr_r[PTR_C_LO]}))
    else $error("third pointer output stale");  // RQ5
  // low i/o offsets must not alias working registers
  a_no_alias: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_io.rd && i_io.addr < OFS_PROT_KEY) |=> o_io_rdata == 8'h00)
    else $error("i/o read reached the register file");  // RQ3
  a_temp_wr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_temp |=> temp_r == $past(i_io.wdata))
    else $error("direct temp write lost");  // RQ10
  a_hi_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_io.rd && i_io.addr == OFS_STACK_HI) |=> o_io_rdata == $past(temp_r))
    else $error("high byte read did not return temp");  // RQ8
  a_rd_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_io.rd |=> o_io_rdata == 8'h00)
    else $error("read data without a read");
endmodule

// *** hdl/crwag_pkg.sv ***
// package: shared constants and carrier types for the cpu register file and access guard
package crwag_pkg;
  // working register file
  localparam int REG_COUNT = 32;
  localparam int REG_AW = 5;
  localparam logic [4:0] PTR_A_LO = 5'h1a;
  localparam logic [4:0] PTR_B_LO = 5'h1c;
  localparam logic [4:0] PTR_C_LO = 5'h1e;
  // i/o offsets
  localparam logic [5:0] OFS_PROT_KEY = 6'h04;
  localparam logic [5:0] OFS_STACK_LO = 6'h0d;
  localparam logic [5:0] OFS_STACK_HI = 6'h0e;
  localparam logic [5:0] OFS_FLAGS = 6'h0f;
  localparam logic [5:0] OFS_TEMP = 6'h10;
  // keys and field positions
  localparam logic [7:0] KEY_IO_UNLOCK = 8'hd8;
  localparam logic [7:0] KEY_SELF_PROG = 8'h9d;
  localparam int BIT_IO_OPEN = 0;
  localparam int BIT_SP_OPEN = 1;
  // reset values
  localparam logic [7:0] RST_PROT_KEY = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_TEMP = 8'h00;
  // window length in instructions
  localparam logic [2:0] WIN_INSTR = 3'h4;

  typedef enum logic [1:0] {
    CRWAG_PM_DISP = 2'b00,
    CRWAG_PM_POSTINC = 2'b01,
    CRWAG_PM_PREDEC = 2'b10
  } crwag_pmode_t;

  typedef enum logic [1:0] {
    CRWAG_PSEL_A = 2'b00,
    CRWAG_PSEL_B = 2'b01,
    CRWAG_PSEL_C = 2'b10
  } crwag_psel_t;

  // register file request from the execution logic
  typedef struct packed {
    logic [4:0] rd_a;
    logic [4:0] rd_b;
    logic wide_rd;
    logic we;
    logic we_wide;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
  } crwag_rf_req_t;

  // pointer request
  typedef struct packed {
    logic valid;
    crwag_psel_t sel;
    crwag_pmode_t mode;
    logic [5:0] disp;
  } crwag_ptr_req_t;

  // i/o bus access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } crwag_io_req_t;

  // events that close the unlock windows
  typedef struct packed {
    logic instr_done;
    logic data_wr;
    logic nvm_ldst;
    logic sleep_exec;
  } crwag_evt_t;

  function automatic logic [4:0] crwag_ptr_base(input crwag_psel_t s);
    case (s)
      CRWAG_PSEL_A: crwag_ptr_base = PTR_A_LO;
      CRWAG_PSEL_B: crwag_ptr_base = PTR_B_LO;
      default: crwag_ptr_base = PTR_C_LO;
    endcase
  endfunction
endpackage

// *** hdl/crwag_wide_reg.sv ***
// 16-bit register on the 8-bit bus with shared temporary byte
module crwag_wide_reg #(
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [15:0] IMPL_MASK = 16'hffff
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // byte access
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic i_rd_lo,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_temp,
  // state
  output logic [15:0] o_value,
  output logic [7:0] o_lo_rd
);
  logic [15:0] val_r;
  logic [15:0] val_nxt;

  // high byte write copies the held low byte in the same cycle
  assign val_nxt = i_wr_hi ? ({i_wdata, i_temp} & IMPL_MASK) : val_r;
  assign o_value = val_r;
  assign o_lo_rd = val_r[7:0];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      val_r <= RST_VAL & IMPL_MASK;
    end else begin
      val_r <= val_nxt;
    end
  end

  a_hi_commit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_wr_hi |=> val_r == ({$past(i_wdata), $past(i_temp)} & IMPL_MASK))
    else $error("wide register high write did not commit temp");  // RQ7
endmodule

// *** hdl/crwag_guard.sv ***
// configuration change protection window counter
module crwag_guard (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // key write and closing events
  input wire logic i_key_wr,
  input wire logic [7:0] i_key,
  input wire logic i_close,
  input wire logic i_instr_done,
  // window state
  output logic o_open,
  output logic o_opening
);
  import crwag_pkg::*;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  // flags the cycle in which a closed window is being opened
  assign o_opening = i_key_wr && !o_open;
  assign o_open = cnt_r != 3'h0;
  // the key write itself is an instruction; the window counts the next four
  assign cnt_nxt = i_key_wr ? WIN_INSTR :
                   i_close ? 3'h0 :
                   (o_open && i_instr_done) ? 3'(cnt_r - 3'h1) : cnt_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_win_len: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_key_wr |=> cnt_r == WIN_INSTR)
    else $error("window did not open at four instructions");  // RQ11
  a_win_close: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_close && !i_key_wr) |=> !o_open)
    else $error("window stayed open after closing event");  // RQ14
endmodule

// *** bench/crwag_cpu_model.sv ***
// model of the execution logic retiring instructions toward the guard
module crwag_cpu_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // retirement
  output logic o_instr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_instr_done = 1'b0;
  // one pulse per retired instruction; a gap models a stalled pipeline
  task automatic retire(int n, int g);
    repeat (n) begin
      o_instr_done = 1'b1;
      @(posedge i_clk);
      #1;
      if (g > 0) begin
        o_instr_done = 1'b0;
        repeat (g) @(posedge i_clk);
        #1;
      end
    end
    o_instr_done = 1'b0;
  endtask
endmodule

// *** bench/tb.sv ***
// self-checking bench for the register file, wide access temp and change guard
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import crwag_pkg::*;
  localparam logic [15:0] SPR = 16'h3ff0;
  localparam logic [15:0] SELF_PROGRAM_KEY = 16'h3fff;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  crwag_rf_req_t rf = '0;
  crwag_ptr_req_t ptr = '0;
  crwag_io_req_t io = '0;
  crwag_evt_t evt;
  logic [2:0] ev = 3'h0;
  logic done_w, ok_p, ok_n, hold;
  logic prot_wr = 1'b0;
  logic nvm_wr = 1'b0;
  logic [7:0] rd_a, rd_b, io_rd, flags;
  logic [15:0] rd_w, paddr, third, sp, got, want;
  logic [3:0] s_m;
  logic [3:0] sel_q[$];
  logic [15:0] exp_q[$];
  logic [7:0] gpr[32];
  int error_cnt = 0;
  int n_checks = 0;
  assign evt = {done_w, ev};
  initial forever #5 i_clk = ~i_clk;
  crwag_top #(.SP_RESET(SPR), .SP_MASK(SELF_PROGRAM_KEY)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_rf(rf), .o_rd_a(rd_a), .o_rd_b(rd_b), .o_rd_wide(rd_w), .i_ptr(ptr),
    .o_ptr_addr(paddr), .o_third_ptr(third), .i_io(io), .o_io_rdata(io_rd), .i_evt(evt),
    .i_prot_wr(prot_wr), .i_nvm_cmd_wr(nvm_wr), .o_prot_wr_ok(ok_p), .o_nvm_cmd_ok(ok_n),
    .o_irq_hold(hold), .o_stack_ptr(sp), .o_flags(flags));
  crwag_cpu_model cpu (.i_clk(i_clk), .i_rst_b(i_rst_b), .o_instr_done(done_w));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] pick(logic [3:0] s);
    case (s)
      4'h0: pick = {8'h00, io_rd};
      4'h1: pick = {8'h00, rd_a};
      4'h2: pick = {8'h00, rd_b};
      4'h3: pick = rd_w;
      4'h4: pick = paddr;
      4'h5: pick = third;
      4'h6: pick = sp;
      4'h7: pick = {8'h00, flags};
      4'h8: pick = {15'h0000, hold};
      default: pick = {14'h0000, ok_p, ok_n};
    endcase
  endfunction
  // notes pushed up to the edge are compared once that edge's updates have landed
  always @(posedge i_clk) begin
    #2;
    while (exp_q.size() > 0) begin
      s_m = sel_q.pop_front();
      want = exp_q.pop_front();
      got = pick(s_m);
      n_checks++;
      if (got !== want) begin
        error_cnt++;
        $display("[FAIL] t=%0t sel %0d got %h exp %h", $time, s_m, got, want);
      end
    end
  end
  task automatic note(logic [3:0] s, logic [15:0] v);
    sel_q.push_back(s);
    exp_q.push_back(v);
  endtask
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic iow(logic [5:0] a, logic [7:0] d);
    io = '{1'b0, 1'b1, a, d};
    tick();
  endtask
  task automatic ior(logic [5:0] a, logic [7:0] e);
    io = '{1'b1, 1'b0, a, 8'h00};
    @(posedge i_clk);
    note(4'h0, {8'h00, e});
    #1;
  endtask
  task automatic idle(int n);
    io = '0;
    rf = '0;
    ptr = '0;
    repeat (n) tick();
  endtask
  task automatic rfx(logic [4:0] a, logic w, logic ww, logic [4:0] wa, logic [15:0] wd);
    rf = '{a, a + 5'h01, a[0], w, ww, wa, wd};
    @(posedge i_clk);
    note(4'h1, {8'h00, gpr[a]});
    note(4'h2, {8'h00, gpr[a + 5'h01]});
    note(4'h3, a[0] ? {gpr[a + 5'h01], gpr[a]} : 16'h0000);
    if (w) gpr[wa] = wd[7:0];
    if (w && ww) gpr[wa + 5'h01] = wd[15:8];
    #1;
  endtask
  task automatic win(logic [7:0] k, int c, int g);
    logic [7:0] st, sa;
    st = {6'h00, k == KEY_SELF_PROG, k == KEY_IO_UNLOCK};
    sa = (c == 1) ? (st & 8'h02) : 8'h00;
    iow(OFS_PROT_KEY, k);
    ior(OFS_PROT_KEY, st);
    note(4'h8, {15'h0000, |st});
    io = '0;
    if (c == 0) begin
      cpu.retire(3, g);
      ior(OFS_PROT_KEY, st);
      io = '0;
      cpu.retire(1, g);
    end else begin
      ev = 3'b100 >> (c - 1);
      tick();
      ev = 3'b000;
    end
    ior(OFS_PROT_KEY, sa);
    note(4'h8, {15'h0000, |sa});
    io = '0;
    ev = 3'b110;
    prot_wr = 1'b1;
    nvm_wr = 1'b1;
    @(posedge i_clk);
    note(4'h9, {14'h0000, sa[0], sa[1]});
    #1;
    ev = 3'b000;
    prot_wr = 1'b0;
    nvm_wr = 1'b0;
    ior(OFS_PROT_KEY, 8'h00);
    note(4'h8, 16'h0000);
    io = '0;
    tick();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v, p;
    logic [7:0] k;
    int b;
    v = $urandom(71);
    repeat (20) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    ior(OFS_STACK_LO, SPR[7:0]);
    ior(OFS_STACK_HI, SPR[15:8]);
    note(4'h6, SPR);
    ior(OFS_PROT_KEY, RST_PROT_KEY);
    ior(OFS_FLAGS, RST_FLAGS);
    ior(6'h05, 8'h00);
    v = $urandom;
    iow(OFS_FLAGS, v[7:0]);
    ior(OFS_FLAGS, v[7:0]);
    note(4'h7, {8'h00, v[7:0]});
    iow(OFS_STACK_LO, v[7:0]);
    ior(OFS_TEMP, v[7:0]);
    note(4'h6, SPR);
    iow(OFS_STACK_HI, v[15:8]);
    p = v & SELF_PROGRAM_KEY;
    ior(OFS_STACK_LO, p[7:0]);
    note(4'h6, p);
    iow(OFS_TEMP, 8'hff);
    iow(OFS_STACK_HI, 8'hff);
    ior(OFS_STACK_LO, 8'hff);
    ior(OFS_TEMP, SELF_PROGRAM_KEY[15:8]);
    iow(OFS_TEMP, v[7:0]);
    ior(OFS_STACK_HI, v[7:0]);
    idle(1);
    $display("test io registers done");
    for (int i = 0; i < 32; i++) begin
      v = $urandom;
      rf = '{5'h00, 5'h00, 1'b0, 1'b1, 1'b0, 5'(i), v};
      gpr[i] = v[7:0];
      tick();
    end
    for (int i = 0; i < 15; i++) begin
      v = $urandom;
      rfx(5'(i), 1'b1, 1'(i), 5'(((i + 8) % 16) * 2), v);
    end
    idle(1);
    iow(6'h01, ~gpr[1]);
    for (int i = 0; i < 31; i++) rfx(5'(i), 1'b0, 1'b0, 5'h00, 16'h0000);
    $display("test register file done");
    for (int i = 0; i < 3; i++) rfx(5'h00, 1'b1, 1'b1, PTR_A_LO + 5'(2 * i), $urandom);
    idle(1);
    note(4'h5, {gpr[31], gpr[30]});
    for (int s = 0; s < 3; s++) begin
      for (int m = 0; m < 3; m++) begin
        b = 26 + 2 * s;
        p = {gpr[b + 1], gpr[b]};
        k = $urandom;
        ptr = '{1'b1, crwag_psel_t'(s), crwag_pmode_t'(m), k[5:0]};
        @(posedge i_clk);
        note(4'h4, m == 0 ? p + {10'h000, k[5:0]} : m == 1 ? p : p - 16'h0001);
        if (m == 1) p = p + 16'h0001;
        if (m == 2) p = p - 16'h0001;
        {gpr[b + 1], gpr[b]} = p;
        #1;
      end
    end
    idle(1);
    note(4'h5, {gpr[31], gpr[30]});
    for (int i = 25; i < 31; i++) rfx(5'(i), 1'b0, 1'b0, 5'h00, 16'h0000);
    idle(1);
    $display("test pointers done");
    for (int c = 0; c < 12; c++) begin
      k = $urandom;
      if (k == KEY_IO_UNLOCK || k == KEY_SELF_PROG) k = 8'h00;
      win(c % 3 == 0 ? KEY_IO_UNLOCK : c % 3 == 1 ? KEY_SELF_PROG : k, c / 3, c % 2 * 3);
    end
    $display("test protection done");
    idle(3);
    stop_test();
  end
  initial begin
    #50000;
    error_cnt++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
